//--- bal_regs.vh
`ifndef BAL_REGS_VH
`define BAL_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets on the apb slave
`define BAL_OFF_CTRL    8'h00
`define BAL_OFF_OPND    8'h04
`define BAL_OFF_FLAGS   8'h08
`define BAL_OFF_STATUS  8'h0C

////////////////////////////////////////////////////////////////////////////////
// field positions
`define BAL_CTRL_OP     3:0
`define BAL_CTRL_START  8
`define BAL_OPND_DST    7:0
`define BAL_OPND_SRC    15:8
`define BAL_OPND_KON    23:16
`define BAL_OPND_HI     31:24
`define BAL_STAT_BUSY   0
`define BAL_STAT_CNT    15:8

// flag bit positions inside the flags register
`define BAL_FLAG_C      0
`define BAL_FLAG_Z      1
`define BAL_FLAG_N      2
`define BAL_FLAG_V      3
`define BAL_FLAG_S      4
`define BAL_FLAG_H      5
`define BAL_FLAG_MASK   8'h3F

////////////////////////////////////////////////////////////////////////////////
// reset values
`define BAL_RST_OP      4'h0
`define BAL_RST_OPND    32'h0000_0000
`define BAL_RST_FLAGS   8'h00
`define BAL_RST_CNT     8'h00
`define BAL_RST_DATA    32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// opcodes
`define BAL_OP_ADD            4'h0
`define BAL_OP_ADD_CARRY      4'h1
`define BAL_OP_WORD_PLUS      4'h2
`define BAL_OP_SUB            4'h3
`define BAL_OP_DIFF_CONST     4'h4
`define BAL_OP_BORROW_REGS    4'h5
`define BAL_OP_BORROW_CONST   4'h6
`define BAL_OP_WORD_MINUS     4'h7
`define BAL_OP_AND            4'h8
`define BAL_OP_AND_CONST      4'h9
`define BAL_OP_OR             4'hA
`define BAL_OP_OR_CONST       4'hB
`define BAL_OP_XOR            4'hC

////////////////////////////////////////////////////////////////////////////////
// cycle counts
`define BAL_WORD_CYC    2'h2
`define BAL_CYC_ONE     2'h1

`endif

//--- bal_byte_unit.v
`timescale 1ns/1ps
`include "bal_regs.vh"

module bal_byte_unit (
    // operation and operands
    input  wire [3:0] op,
    input  wire [7:0] dst,
    input  wire [7:0] src,
    input  wire [7:0] kon,
    input  wire [7:0] flags_in,
    // result
    output reg  [7:0] res,
    output reg  [7:0] flags_out,
    output reg        hit
);

    reg [7:0] b;
    reg       cin;
    reg [1:0] kind;
    reg [8:0] full;
    reg [4:0] half;

    always @* begin
        b         = src;
        cin       = 1'b0;
        kind      = 2'h0;
        hit       = 1'b1;
        flags_out = flags_in;
        case (op)
            `BAL_OP_ADD: begin
                kind = 2'h0;
            end
            `BAL_OP_ADD_CARRY: begin
                cin = flags_in[`BAL_FLAG_C];
            end
            `BAL_OP_SUB: begin
                kind = 2'h1;
            end
            `BAL_OP_DIFF_CONST: begin
                kind = 2'h1;
                b    = kon;
            end
            `BAL_OP_BORROW_REGS: begin
                kind = 2'h1;
                cin  = flags_in[`BAL_FLAG_C];
            end
            `BAL_OP_BORROW_CONST: begin
                kind = 2'h1;
                b    = kon;
                cin  = flags_in[`BAL_FLAG_C];
            end
            `BAL_OP_AND, `BAL_OP_OR, `BAL_OP_XOR: begin
                kind = 2'h2;
            end
            `BAL_OP_AND_CONST, `BAL_OP_OR_CONST: begin
                kind = 2'h2;
                b    = kon;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (kind == 2'h1) begin
            full = {1'b0, dst} - {1'b0, b} - {8'h00, cin};
            half = {1'b0, dst[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        end else begin
            full = {1'b0, dst} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, dst[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        end
        case (op)
            `BAL_OP_AND, `BAL_OP_AND_CONST: res = dst & b;
            `BAL_OP_OR, `BAL_OP_OR_CONST:   res = dst | b;
            `BAL_OP_XOR:                    res = dst ^ b;
            default:                        res = full[7:0];
        endcase
        // s is never touched by byte operations
        flags_out[`BAL_FLAG_Z] = (res == 8'h00);
        flags_out[`BAL_FLAG_N] = res[7];
        if (kind == 2'h2) begin
            flags_out[`BAL_FLAG_V] = 1'b0;
        end else begin
            flags_out[`BAL_FLAG_C] = full[8];
            flags_out[`BAL_FLAG_H] = half[4];
            if (kind == 2'h1) begin
                flags_out[`BAL_FLAG_V] = (dst[7] != b[7]) && (res[7] != dst[7]);
            end else begin
                flags_out[`BAL_FLAG_V] = (dst[7] == b[7]) && (res[7] != dst[7]);
            end
        end
        if (!hit) begin
            flags_out = flags_in;
        end
    end

endmodule

//--- bal_word_unit.v
`timescale 1ns/1ps
`include "bal_regs.vh"

module bal_word_unit (
    // operation and operands
    input  wire [3:0]  op,
    input  wire [7:0]  hi,
    input  wire [7:0]  lo,
    input  wire [7:0]  kon,
    input  wire [7:0]  flags_in,
    // result
    output reg  [15:0] res,
    output reg  [7:0]  flags_out,
    output reg         hit
);

    reg [16:0] full;
    reg        minus;
    reg        ovf;

    always @* begin
        hit   = (op == `BAL_OP_WORD_PLUS) || (op == `BAL_OP_WORD_MINUS);
        minus = (op == `BAL_OP_WORD_MINUS);
        if (minus) begin
            full = {1'b0, hi, lo} - {9'h000, kon};
        end else begin
            full = {1'b0, hi, lo} + {9'h000, kon};
        end
        res = full[15:0];
        // the constant is never negative, so overflow is a sign flip
        if (minus) begin
            ovf = hi[7] & ~res[15];
        end else begin
            ovf = ~hi[7] & res[15];
        end
        flags_out = flags_in;
        if (hit) begin
            flags_out[`BAL_FLAG_C] = full[16];
            flags_out[`BAL_FLAG_Z] = (res == 16'h0000);
            flags_out[`BAL_FLAG_N] = res[15];
            flags_out[`BAL_FLAG_V] = ovf;
            flags_out[`BAL_FLAG_S] = res[15] ^ ovf;
        end
    end

endmodule

//--- bal_alu_top.v
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bal_regs.vh"

module bal_alu_top #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // apb request
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    // apb answer
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // status
    output reg               busy
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    reg [3:0]  op_sel;
    reg [31:0] opnd;
    reg [7:0]  flags;
    reg [7:0]  done_cnt;
    reg [1:0]  cyc;

    ////////////////////////////////////////////////////////////////////////////
    // register select codes

    // code zero marks an unmapped place: it answers with an error and no effect
    localparam [2:0] SEL_NONE   = 3'h0;
    localparam [2:0] SEL_CTRL   = 3'h1;
    localparam [2:0] SEL_OPND   = 3'h2;
    localparam [2:0] SEL_FLAGS  = 3'h3;
    localparam [2:0] SEL_STATUS = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function [2:0] reg_index;
        input [ADDR_W-1:0] a;
        begin
            case (a[7:0])
                `BAL_OFF_CTRL:   reg_index = SEL_CTRL;
                `BAL_OFF_OPND:   reg_index = SEL_OPND;
                `BAL_OFF_FLAGS:  reg_index = SEL_FLAGS;
                `BAL_OFF_STATUS: reg_index = SEL_STATUS;
                default:         reg_index = SEL_NONE;
            endcase
            if (ADDR_W > 8) begin
                if ((a >> 8) != 0) begin
                    reg_index = SEL_NONE;
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // bits 7:6 of the flags word do not exist; masking both ways keeps them zero
    function [7:0] flag_bits;
        input [7:0] f;
        begin
            flag_bits = f & `BAL_FLAG_MASK;
        end
    endfunction

    // the completed-op tally wraps silently; software only takes differences
    function [7:0] count_step;
        input [7:0] c;
        begin
            count_step = c + 8'h01;
        end
    endfunction

    wire [2:0] idx      = reg_index(paddr);
    wire       acc_wait = psel & penable & ~pready;
    wire       acc_done = psel & penable & pready;
    wire       wr_done  = acc_done & pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // write strobes

    // a write lands only on the edge where pready is seen with psel and penable
    // writes to the operating registers are dropped while a word op runs
    wire       wr_ok    = wr_done & ~busy;
    wire       wr_ctrl  = wr_ok & (idx == SEL_CTRL);
    wire       wr_opnd  = wr_ok & (idx == SEL_OPND);
    wire       wr_flags = wr_ok & (idx == SEL_FLAGS);
    wire       start    = wr_ctrl & pwdata[`BAL_CTRL_START];

    ////////////////////////////////////////////////////////////////////////////
    // datapath

    // a start uses the opcode written with it; a running word op its latch
    wire [3:0]  exec_op = busy ? op_sel : pwdata[`BAL_CTRL_OP];
    wire [7:0]  byte_res;
    wire [7:0]  byte_flags;
    wire        byte_hit;
    wire [15:0] word_res;
    wire [7:0]  word_flags;
    wire        word_hit;

    bal_byte_unit u_byte (
        .op        (exec_op),
        .dst       (opnd[`BAL_OPND_DST]),
        .src       (opnd[`BAL_OPND_SRC]),
        .kon       (opnd[`BAL_OPND_KON]),
        .flags_in  (flags),
        .res       (byte_res),
        .flags_out (byte_flags),
        .hit       (byte_hit)
    );

    bal_word_unit u_word (
        .op        (exec_op),
        .hi        (opnd[`BAL_OPND_HI]),
        .lo        (opnd[`BAL_OPND_DST]),
        .kon       (opnd[`BAL_OPND_KON]),
        .flags_in  (flags),
        .res       (word_res),
        .flags_out (word_flags),
        .hit       (word_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // execution strobes

    // the two units decode disjoint opcodes, so at most one go fires per start
    wire byte_go   = start & byte_hit;
    wire word_go   = start & word_hit;
    wire word_last = busy & (cyc == `BAL_WORD_CYC - `BAL_CYC_ONE);

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    reg [31:0] next_rdata;

    always @* begin
        next_rdata = `BAL_RST_DATA;
        case (idx)
            SEL_CTRL: begin
                next_rdata[`BAL_CTRL_OP] = op_sel;
            end
            SEL_OPND: begin
                next_rdata = opnd;
            end
            SEL_FLAGS: begin
                next_rdata[7:0] = flag_bits(flags);
            end
            SEL_STATUS: begin
                next_rdata[`BAL_STAT_BUSY] = busy;
                next_rdata[`BAL_STAT_CNT]  = done_cnt;
            end
            default: begin
                next_rdata = `BAL_RST_DATA;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: next values

    reg [31:0] next_prdata;
    reg        next_pready;
    reg        next_pslverr;

    always @* begin
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (acc_wait) begin
            // write answers carry zero data so no stale read leaks out
            next_pready  = 1'b1;
            next_pslverr = (idx == SEL_NONE);
            next_prdata  = pwrite ? `BAL_RST_DATA : next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: one wait state keeps every output on a flip-flop

    // read data is held, not cleared, once pready falls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `BAL_RST_DATA;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register and word sequencing

    reg [3:0] next_op_sel;
    reg       next_busy;
    reg [1:0] next_cyc;

    always @* begin
        next_op_sel = op_sel;
        next_busy   = busy;
        next_cyc    = cyc;
        if (wr_ctrl) begin
            // an opcode outside the table is still stored; it just never starts
            next_op_sel = pwdata[`BAL_CTRL_OP];
        end
        if (word_go) begin
            next_busy = 1'b1;
            next_cyc  = `BAL_CYC_ONE;
        end else if (word_last) begin
            next_busy = 1'b0;
            next_cyc  = 2'h0;
        end else if (busy) begin
            next_cyc = cyc + `BAL_CYC_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control flops

    // cyc counts the cycles a word op has run; it is zero whenever idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_sel <= `BAL_RST_OP;
            busy   <= 1'b0;
            cyc    <= 2'h0;
        end else begin
            op_sel <= next_op_sel;
            busy   <= next_busy;
            cyc    <= next_cyc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operands, result write-back and flags

    reg [31:0] next_opnd;
    reg [7:0]  next_flags;
    reg [7:0]  next_cnt;

    // a flags write cannot meet a commit: starts come only from ctrl writes
    always @* begin
        next_opnd  = opnd;
        next_flags = flags;
        next_cnt   = done_cnt;
        if (wr_opnd) begin
            next_opnd = pwdata;
        end
        if (wr_flags) begin
            next_flags = flag_bits(pwdata[7:0]);
        end
        if (byte_go) begin
            // byte ops finish on the edge that takes the start
            next_opnd[`BAL_OPND_DST] = byte_res;
            next_flags               = byte_flags;
            next_cnt                 = count_step(done_cnt);
        end
        if (word_last) begin
            // the pair and its flags change only once, at the end
            next_opnd[`BAL_OPND_DST] = word_res[7:0];
            next_opnd[`BAL_OPND_HI]  = word_res[15:8];
            next_flags               = word_flags;
            next_cnt                 = count_step(done_cnt);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand and flag flops

    // one register stage for all operating state, so every read sees settled values
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd     <= `BAL_RST_OPND;
            flags    <= `BAL_RST_FLAGS;
            done_cnt <= `BAL_RST_CNT;
        end else begin
            opnd     <= next_opnd;
            flags    <= next_flags;
            done_cnt <= next_cnt;
        end
    end

endmodule

//--- bal_alu_properties.sv
`timescale 1ns/1ps
`include "bal_regs.vh"

module bal_alu_properties #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input wire              pclk,
    input wire              presetn,
    // apb request
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    // apb answer and status
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    input wire              busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    // a start only counts while idle: writes during a word op are dropped
    wire       start = psel && penable && pready && pwrite && !busy
                       && paddr == `BAL_OFF_CTRL && pwdata[`BAL_CTRL_START];
    wire [3:0] op    = pwdata[`BAL_CTRL_OP];

    ////////////////////////////////////////////////////////////////////////////
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");

    property p_err_data;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error answer malformed");

    property p_err_unmapped;
        psel && penable && pready && paddr > `BAL_OFF_STATUS |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

    property p_word_plus;
        start && op == `BAL_OP_WORD_PLUS |=> busy ##1 !busy;
    endproperty
    a_word_plus: assert property (p_word_plus) else $error("word add not two cycles");

    property p_word_minus;
        start && op == `BAL_OP_WORD_MINUS |=> busy ##1 !busy;
    endproperty
    a_word_minus: assert property (p_word_minus) else $error("word sub not two cycles");

    property p_add_one;
        start && op <= `BAL_OP_ADD_CARRY |=> !busy [*2];
    endproperty
    a_add_one: assert property (p_add_one) else $error("byte add went busy");

    property p_sub_one;
        start && op >= `BAL_OP_SUB && op <= `BAL_OP_BORROW_CONST |=> !busy [*2];
    endproperty
    a_sub_one: assert property (p_sub_one) else $error("byte sub went busy");

    property p_logic_one;
        start && op >= `BAL_OP_AND && op <= `BAL_OP_XOR |=> !busy [*2];
    endproperty
    a_logic_one: assert property (p_logic_one) else $error("logic op went busy");

    property p_busy_once;
        $rose(busy) |-> $past(start) ##1 !busy;
    endproperty
    a_busy_once: assert property (p_busy_once) else $error("busy without start");
endmodule

bind bal_alu_top bal_alu_properties #(.ADDR_W(ADDR_W)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));

//--- bal_core_model.sv
`timescale 1ns/1ps

module bal_core_model #(
    parameter ADDR_W = 8
) (
    // clock
    input  wire              pclk,
    // apb answer
    input  wire [31:0]       prdata,
    input  wire              pready,
    input  wire              pslverr,
    // apb request
    output reg               psel,
    output reg               penable,
    output reg               pwrite,
    output reg  [ADDR_W-1:0] paddr,
    output reg  [31:0]       pwdata
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = {ADDR_W{1'b0}};
        pwdata  = 32'h0000_0000;
    end

    task xfer(input w, input [ADDR_W-1:0] a, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            q = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            // released lines show junk so a stale value cannot pass for a held one
            paddr   <= ~a;
            pwdata  <= ~d;
        end
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "bal_regs.vh"

module tb_top;
    localparam AW = 8;
    reg          pclk    = 1'b0;
    reg          presetn = 1'b0;
    wire         psel, penable, pwrite, pready, pslverr, busy;
    wire [AW-1:0] paddr;
    wire [31:0]  pwdata, prdata;
    integer      mismatches  = 0;
    integer      check_count = 0;
    integer      i, j, ops;
    reg  [31:0]  q, eo, vo [0:2];
    reg  [7:0]   ef, vf [0:2];
    reg          er, word;

    always #5 pclk = ~pclk;

    bal_core_model #(.ADDR_W(AW)) u_core (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    bal_alu_top #(.ADDR_W(AW)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task wr(input [AW-1:0] a, input [31:0] d);
        u_core.xfer(1'b1, a, d, q, er);
    endtask

    // reference result: flags C0 Z1 N2 V3 S4 H5
    task model(input [3:0] op, input [31:0] o, input [7:0] f);
        reg [7:0]  d, s, r;
        reg [8:0]  t;
        reg [4:0]  h;
        reg [16:0] w;
        reg        b, sb;
        begin
            d  = o[7:0];
            sb = op >= `BAL_OP_SUB;
            s  = (op == `BAL_OP_DIFF_CONST || op == `BAL_OP_BORROW_CONST) ? o[23:16] : o[15:8];
            b  = (op == `BAL_OP_ADD_CARRY || op == `BAL_OP_BORROW_REGS
                  || op == `BAL_OP_BORROW_CONST) & f[0];
            eo = o;
            ef = f;
            if (op == `BAL_OP_WORD_PLUS || op == `BAL_OP_WORD_MINUS) begin
                w = sb ? {1'b0, o[31:24], d} - o[23:16] : {1'b0, o[31:24], d} + o[23:16];
                eo[7:0]   = w[7:0];
                eo[31:24] = w[15:8];
                ef[0] = w[16];
                ef[1] = w[15:0] == 16'h0000;
                ef[2] = w[15];
                ef[3] = sb ? o[31] & ~w[15] : ~o[31] & w[15];
                ef[4] = w[15] ^ ef[3];
            end
            else begin
                if (op >= `BAL_OP_AND) begin
                    case (op)
                        `BAL_OP_AND:       r = d & o[15:8];
                        `BAL_OP_AND_CONST: r = d & o[23:16];
                        `BAL_OP_OR:        r = d | o[15:8];
                        `BAL_OP_OR_CONST:  r = d | o[23:16];
                        default:           r = d ^ o[15:8];
                    endcase
                    ef[3] = 1'b0;
                end
                else begin
                    t = sb ? {1'b0, d} - s - b : {1'b0, d} + s + b;
                    h = sb ? {1'b0, d[3:0]} - s[3:0] - b : {1'b0, d[3:0]} + s[3:0] + b;
                    r = t[7:0];
                    ef[0] = t[8];
                    ef[5] = h[4];
                    ef[3] = sb ? (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7])
                               : (d[7] & s[7] & ~r[7]) | (~d[7] & ~s[7] & r[7]);
                end
                eo[7:0] = r;
                ef[1]   = r == 8'h00;
                ef[2]   = r[7];
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        mismatches = mismatches + 1;
        finish_test;
    end

    initial begin
        vo[0] = 32'h7F80_010F;
        vf[0] = 8'h3F;
        vo[1] = 32'h0001_0000;
        vf[1] = 8'h00;
        vo[2] = 32'hFFFF_FFFF;
        vf[2] = 8'h15;
        ops   = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            u_core.xfer(1'b0, i * 4, 32'h0000_0000, q, er);
            check("reset value", q, 32'h0000_0000);
            check("reset err", {31'h0, er}, 32'h0000_0000);
        end
        // unmapped place is refused
        u_core.xfer(1'b0, 8'h10, 32'h0000_0000, q, er);
        check("unmapped err", {31'h0, er}, 32'h0000_0001);
        check("unmapped data", q, 32'h0000_0000);
        // an opcode outside the table is stored but runs nothing
        wr(`BAL_OFF_FLAGS, 32'h0000_002A);
        wr(`BAL_OFF_OPND, 32'h1234_5678);
        wr(`BAL_OFF_CTRL, 32'h0000_010F);
        #1;
        check("idle op busy", {31'h0, busy}, 32'h0000_0000);
        u_core.xfer(1'b0, `BAL_OFF_OPND, 32'h0000_0000, q, er);
        check("idle op opnd", q, 32'h1234_5678);
        u_core.xfer(1'b0, `BAL_OFF_FLAGS, 32'h0000_0000, q, er);
        check("idle op flags", q, 32'h0000_002A);
        u_core.xfer(1'b0, `BAL_OFF_CTRL, 32'h0000_0000, q, er);
        check("idle op ctrl", q, 32'h0000_000F);
        for (j = 0; j < 3; j = j + 1) begin
            for (i = 0; i < 13; i = i + 1) begin
                word = (i == `BAL_OP_WORD_PLUS || i == `BAL_OP_WORD_MINUS);
                model(i[3:0], vo[j], vf[j]);
                wr(`BAL_OFF_FLAGS, {24'h0, vf[j]});
                wr(`BAL_OFF_OPND, vo[j]);
                wr(`BAL_OFF_CTRL, {23'h0, 1'b1, 4'h0, i[3:0]});
                #1;
                check("busy", {31'h0, busy}, {31'h0, word});
                ops = ops + 1;
                u_core.xfer(1'b0, `BAL_OFF_OPND, 32'h0000_0000, q, er);
                check("result", q, eo);
                u_core.xfer(1'b0, `BAL_OFF_FLAGS, 32'h0000_0000, q, er);
                check("flags", q, {24'h0, ef});
            end
        end
        // status is read-only: a write must not disturb the tally
        wr(`BAL_OFF_STATUS, 32'hFFFF_FFFF);
        u_core.xfer(1'b0, `BAL_OFF_STATUS, 32'h0000_0000, q, er);
        check("status", q, {16'h0, ops[7:0], 8'h00});
        u_core.xfer(1'b0, `BAL_OFF_CTRL, 32'h0000_0000, q, er);
        check("ctrl", q, 32'h0000_000C);
        finish_test;
    end
endmodule
